// ===== inc/rssd_pkg.sv
// How it works
// - Rotate left into working register, flags kept
// - Rotate left through carry, result to memory
// - Same carry rotation, result to working register
// - Rotate right to memory, flags kept
// - Rotate right into working register, memory kept
// - Rotate right through carry, result to memory
// - Right carry rotation into working register
// - Working minus operand minus inverted carry
// - Borrow subtract result goes to memory
// - Carry is inverted borrow after subtraction
// - Subtraction updates all six arithmetic flags
// - Plain subtract into working register
// - Plain subtract result goes to memory
// - Decrement memory, skip when zero
// - Decrement into working register, skip on zero
// - Increment memory, skip when zero
// - Increment into working register, skip on zero
// - Skip instructions take two cycles
// - Skip when selected memory bit set
// - Write byte back, skip when nonzero
// - Set whole memory byte to ones
// - Set only the selected bit
package rssd_pkg;

    // ****************************************
    // Register map (byte addresses)
    // ****************************************
    localparam logic [4:0] RSSD_OFS_CMD = 5'h00;
    localparam logic [4:0] RSSD_OFS_MEM = 5'h04;
    localparam logic [4:0] RSSD_OFS_IMM = 5'h08;
    localparam logic [4:0] RSSD_OFS_WORK = 5'h0c;
    localparam logic [4:0] RSSD_OFS_FLAGS = 5'h10;
    localparam logic [4:0] RSSD_OFS_RESULT = 5'h14;

    // Command register fields
    localparam int RSSD_CMD_OP_LSB = 0;
    localparam int RSSD_CMD_BIT_LSB = 8;

    // Flag bit positions
    localparam int RSSD_FL_C = 0;
    localparam int RSSD_FL_AC = 1;
    localparam int RSSD_FL_Z = 2;
    localparam int RSSD_FL_OV = 3;
    localparam int RSSD_FL_SC = 4;
    localparam int RSSD_FL_CZ = 5;

    // Result register fields
    localparam int RSSD_RES_WE = 8;
    localparam int RSSD_RES_SKIP = 9;
    localparam int RSSD_RES_BUSY = 10;

    // Reset values and the all-ones set-byte pattern
    localparam logic [7:0] RSSD_RST_BYTE = 8'h00;
    localparam logic [5:0] RSSD_RST_FLAGS = 6'h00;
    localparam logic [7:0] RSSD_ALL_ONES = 8'hff;

    typedef enum logic [4:0] {
        RSSD_OP_ROT_L_W = 5'h00,
        RSSD_OP_ROT_L_C = 5'h01,
        RSSD_OP_ROT_L_CW = 5'h02,
        RSSD_OP_ROT_R_M = 5'h03,
        RSSD_OP_ROT_R_W = 5'h04,
        RSSD_OP_ROT_R_C = 5'h05,
        RSSD_OP_ROT_R_CW = 5'h06,
        RSSD_OP_SBC_M = 5'h07,
        RSSD_OP_SBC_I = 5'h08,
        RSSD_OP_SBC_TO_M = 5'h09,
        RSSD_OP_SUB_M = 5'h0a,
        RSSD_OP_SUB_I = 5'h0b,
        RSSD_OP_SUB_TO_M = 5'h0c,
        RSSD_OP_DEC_SKIP = 5'h0d,
        RSSD_OP_DEC_SKIP_W = 5'h0e,
        RSSD_OP_INC_SKIP = 5'h0f,
        RSSD_OP_INC_SKIP_W = 5'h10,
        RSSD_OP_SKIP_BIT_NZ = 5'h11,
        RSSD_OP_SKIP_NZ = 5'h12,
        RSSD_OP_SET_BYTE = 5'h13,
        RSSD_OP_SET_BIT = 5'h14
    } rssd_op_t;

    typedef enum logic [2:0] {
        RSSD_ST_IDLE = 3'b001,
        RSSD_ST_EXEC = 3'b010,
        RSSD_ST_DUMMY = 3'b100
    } rssd_state_t;

    typedef struct packed {
        logic sign_flag;
        logic chain_null;
        logic signed_wrap;
        logic null_flag;
        logic half_nibble;
        logic carry;
    } rssd_flags_t;

    typedef struct packed {
        rssd_state_t state;
        logic [4:0] op;
        logic [2:0] bit_sel;
        logic [7:0] mem_byte;
        logic [7:0] imm_byte;
        logic [7:0] working;
        logic [5:0] flags;
        logic [7:0] mem_result;
        logic mem_we;
        logic skip;
        logic skip_out;
        logic waitreq;
        logic [31:0] rdata;
    } rssd_regs_t;

endpackage

// ===== rtl/rssd_datapath.sv
// The Avalon-MM interface to the registers and the register offsets were decided locally.
`timescale 1ns/100ps
module rssd_datapath
    import rssd_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [3:0] avs_byteenable,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output logic mem_write,
    output logic [7:0] mem_data,
    output logic skip_next,
    output logic [7:0] working_register,
    output logic [5:0] flag_bits
);

    rssd_regs_t q;
    rssd_regs_t d;

    logic req;
    logic commit;
    logic [7:0] a;
    logic [7:0] m;
    logic [7:0] b;
    logic borrow;
    logic [8:0] diff;
    logic [4:0] nib;
    logic [7:0] r;
    logic ov;
    logic [7:0] dec_v;
    logic [7:0] inc_v;
    logic c_in;
    logic [7:0] bit_mask;
    logic [31:0] rd_mux;

    // ****************************************
    // Arithmetic
    // ****************************************
    always_comb begin
        a = q.working;
        m = q.mem_byte;
        c_in = q.flags[RSSD_FL_C];
        b = (q.op == RSSD_OP_SBC_I || q.op == RSSD_OP_SUB_I) ? q.imm_byte : m;
        // Carry acts as inverted borrow on input too
        borrow = 1'b0;
        if (q.op == RSSD_OP_SBC_M || q.op == RSSD_OP_SBC_I || q.op == RSSD_OP_SBC_TO_M) begin
            borrow = ~c_in;
        end
        diff = {1'b0, a} - {1'b0, b} - {8'h00, borrow};
        nib = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, borrow};
        r = diff[7:0];
        ov = (a[7] != b[7]) && (r[7] != a[7]);
        dec_v = m - 8'h01;
        inc_v = m + 8'h01;
        bit_mask = 8'h01 << q.bit_sel;
    end

    // ****************************************
    // Register read mux
    // ****************************************
    always_comb begin
        rd_mux = 32'h0000_0000;
        unique case ({avs_address[4:2], 2'b00})
            RSSD_OFS_CMD: rd_mux = {16'h0000, 5'h00, q.bit_sel, 3'h0, q.op};
            RSSD_OFS_MEM: rd_mux = {24'h000000, q.mem_byte};
            RSSD_OFS_IMM: rd_mux = {24'h000000, q.imm_byte};
            RSSD_OFS_WORK: rd_mux = {24'h000000, q.working};
            RSSD_OFS_FLAGS: rd_mux = {26'h0, q.flags};
            RSSD_OFS_RESULT: rd_mux = {21'h0, q.state != RSSD_ST_IDLE, q.skip,
                q.mem_we, q.mem_result};
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        d = q;
        d.mem_we = 1'b0;
        d.skip_out = 1'b0;
        req = avs_read || avs_write;
        // Accesses stall while an instruction runs so state never changes under it
        commit = req && !q.waitreq;
        if (req && q.waitreq && q.state == RSSD_ST_IDLE) begin
            d.waitreq = 1'b0;
            d.rdata = rd_mux;
        end
        if (commit) begin
            d.waitreq = 1'b1;
            if (avs_write && avs_byteenable[0]) begin
                unique case ({avs_address[4:2], 2'b00})
                    RSSD_OFS_CMD: begin
                        d.op = avs_writedata[RSSD_CMD_OP_LSB +: 5];
                        d.state = RSSD_ST_EXEC;
                        d.skip = 1'b0;
                    end
                    RSSD_OFS_MEM: d.mem_byte = avs_writedata[7:0];
                    RSSD_OFS_IMM: d.imm_byte = avs_writedata[7:0];
                    RSSD_OFS_WORK: d.working = avs_writedata[7:0];
                    RSSD_OFS_FLAGS: d.flags = avs_writedata[5:0];
                    default: d.waitreq = 1'b1;
                endcase
            end
            if (avs_write && avs_byteenable[1] && {avs_address[4:2], 2'b00} == RSSD_OFS_CMD) begin
                d.bit_sel = avs_writedata[RSSD_CMD_BIT_LSB +: 3];
            end
        end

        unique case (q.state)
            // Skip result stays readable until a new command clears it
            RSSD_ST_IDLE: d.skip_out = 1'b0;
            RSSD_ST_EXEC: begin
                d.state = RSSD_ST_IDLE;
                unique case (q.op)
                    RSSD_OP_ROT_L_W: d.working = {m[6:0], m[7]};
                    RSSD_OP_ROT_L_C: begin
                        d.mem_result = {m[6:0], c_in};
                        d.mem_we = 1'b1;
                        d.flags[RSSD_FL_C] = m[7];
                    end
                    RSSD_OP_ROT_L_CW: begin
                        d.working = {m[6:0], c_in};
                        d.flags[RSSD_FL_C] = m[7];
                    end
                    RSSD_OP_ROT_R_M: begin
                        d.mem_result = {m[0], m[7:1]};
                        d.mem_we = 1'b1;
                    end
                    RSSD_OP_ROT_R_W: d.working = {m[0], m[7:1]};
                    RSSD_OP_ROT_R_C: begin
                        d.mem_result = {c_in, m[7:1]};
                        d.mem_we = 1'b1;
                        d.flags[RSSD_FL_C] = m[0];
                    end
                    RSSD_OP_ROT_R_CW: begin
                        d.working = {c_in, m[7:1]};
                        d.flags[RSSD_FL_C] = m[0];
                    end
                    RSSD_OP_SBC_M, RSSD_OP_SBC_I, RSSD_OP_SBC_TO_M,
                    RSSD_OP_SUB_M, RSSD_OP_SUB_I, RSSD_OP_SUB_TO_M: begin
                        if (q.op == RSSD_OP_SBC_TO_M || q.op == RSSD_OP_SUB_TO_M) begin
                            d.mem_result = r;
                            d.mem_we = 1'b1;
                        end else begin
                            d.working = r;
                        end
                        d.flags[RSSD_FL_C] = ~diff[8];
                        d.flags[RSSD_FL_AC] = ~nib[4];
                        d.flags[RSSD_FL_Z] = (r == 8'h00);
                        d.flags[RSSD_FL_OV] = ov;
                        d.flags[RSSD_FL_SC] = r[7] ^ ov;
                        // Chained zero keeps multi-byte zero test across borrow steps
                        d.flags[RSSD_FL_CZ] = (r == 8'h00) && (borrow == 1'b0 ?
                            (q.op == RSSD_OP_SUB_M || q.op == RSSD_OP_SUB_I ||
                            q.op == RSSD_OP_SUB_TO_M || q.flags[RSSD_FL_CZ]) :
                            q.flags[RSSD_FL_CZ]);
                    end
                    RSSD_OP_DEC_SKIP: begin
                        d.mem_result = dec_v;
                        d.mem_we = 1'b1;
                        d.skip = (dec_v == 8'h00);
                    end
                    RSSD_OP_DEC_SKIP_W: begin
                        d.working = dec_v;
                        d.skip = (dec_v == 8'h00);
                    end
                    RSSD_OP_INC_SKIP: begin
                        d.mem_result = inc_v;
                        d.mem_we = 1'b1;
                        d.skip = (inc_v == 8'h00);
                    end
                    RSSD_OP_INC_SKIP_W: begin
                        d.working = inc_v;
                        d.skip = (inc_v == 8'h00);
                    end
                    RSSD_OP_SKIP_BIT_NZ: d.skip = |(m & bit_mask);
                    RSSD_OP_SKIP_NZ: begin
                        d.mem_result = m;
                        d.mem_we = 1'b1;
                        d.skip = (m != 8'h00);
                    end
                    RSSD_OP_SET_BYTE: begin
                        d.mem_result = RSSD_ALL_ONES;
                        d.mem_we = 1'b1;
                    end
                    RSSD_OP_SET_BIT: begin
                        d.mem_result = m | bit_mask;
                        d.mem_we = 1'b1;
                    end
                    default: d.state = RSSD_ST_IDLE;
                endcase
                if (q.op >= RSSD_OP_DEC_SKIP && q.op <= RSSD_OP_SKIP_NZ) begin
                    d.state = RSSD_ST_DUMMY;
                    d.skip_out = d.skip;
                end
                if (d.mem_we) begin
                    d.mem_byte = d.mem_result;
                end
            end
            RSSD_ST_DUMMY: d.state = RSSD_ST_IDLE;
            default: d.state = RSSD_ST_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            q <= '{state: RSSD_ST_IDLE, op: 5'h00, bit_sel: 3'h0,
                mem_byte: RSSD_RST_BYTE, imm_byte: RSSD_RST_BYTE, working: RSSD_RST_BYTE,
                flags: RSSD_RST_FLAGS, mem_result: RSSD_RST_BYTE, mem_we: 1'b0,
                skip: 1'b0, skip_out: 1'b0, waitreq: 1'b1, rdata: 32'h0000_0000};
        end else begin
            q <= d;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign avs_readdata = q.rdata;
    assign avs_waitrequest = q.waitreq;
    assign mem_write = q.mem_we;
    assign mem_data = q.mem_result;
    // Skip raised during the dummy cycle so the fetch unit can discard it
    assign skip_next = q.skip_out;
    assign working_register = q.working;
    assign flag_bits = q.flags;

endmodule

// ===== test/rssd_mem_model.sv
`timescale 1ns/100ps
// ****************************************
// Data memory seen from the datapath
// ****************************************
module rssd_mem_model (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic mem_write,
    input wire logic [7:0] mem_data,
    output logic [15:0] wr_cnt,
    output logic [7:0] last_byte
);
    // One byte is enough: the datapath addresses one location per command
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            wr_cnt <= 16'h0000;
            last_byte <= 8'h00;
        end else if (mem_write) begin
            wr_cnt <= wr_cnt + 16'h0001;
            last_byte <= mem_data;
        end
    end
endmodule

// ===== test/rssd_datapath_asserts.sv
`timescale 1ns/100ps
module rssd_datapath_asserts
    import rssd_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [4:0] avs_address,
    input wire logic avs_write,
    input wire logic [3:0] avs_byteenable,
    input wire logic [31:0] avs_writedata,
    input wire logic avs_waitrequest,
    input wire logic mem_write,
    input wire logic [7:0] mem_data,
    input wire logic skip_next,
    input wire logic [5:0] flag_bits
);
    logic cmd_go;
    logic [4:0] cmd_op;
    logic [2:0] bit_q;
    assign cmd_go = avs_write && !avs_waitrequest && avs_byteenable[0]
        && avs_address[4:2] == RSSD_OFS_CMD[4:2];
    assign cmd_op = avs_writedata[4:0];
    // Bit select is kept so the set-bit result can be checked later
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            bit_q <= 3'h0;
        end else if (cmd_go && avs_byteenable[1]) begin
            bit_q <= avs_writedata[10:8];
        end
    end
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);
    AST_SKIP_ONE_CYCLE: assert property (skip_next |=> !skip_next)
        else $error("skip pulse longer than one cycle");
    AST_SKIP_ONLY_SKIPOPS: assert property (
        cmd_go && !(cmd_op inside {[5'h0d:5'h12]}) |=> !skip_next [*6])
        else $error("skip raised by a non-skip command");
    AST_SET_BYTE: assert property (
        cmd_go && cmd_op == 5'h13 |-> ##[1:4] (mem_write && mem_data == 8'hff))
        else $error("set byte did not write all ones");
    AST_SET_BIT: assert property (
        cmd_go && cmd_op == 5'h14 |-> ##[1:4] (mem_write && mem_data[bit_q]))
        else $error("set bit left selected bit clear");
    AST_W_OPS_NO_MEMW: assert property (
        cmd_go && cmd_op inside {5'h00, 5'h02, 5'h04, 5'h06, 5'h07, 5'h08, 5'h0a,
            5'h0b, 5'h0e, 5'h10, 5'h11} |=> !mem_write [*5])
        else $error("memory written by a working register op");
    AST_M_OPS_MEMW: assert property (
        cmd_go && cmd_op inside {5'h01, 5'h03, 5'h05, 5'h09, 5'h0c, 5'h0d, 5'h0f,
            5'h12} |-> ##[1:4] mem_write)
        else $error("memory op gave no memory write");
    AST_FLAGS_KEPT: assert property (
        cmd_go && cmd_op inside {5'h00, 5'h03, 5'h04, [5'h0d:5'h14]}
        |=> $stable(flag_bits) [*4])
        else $error("flags changed by a flag-neutral op");
    AST_CARRY_ONLY: assert property (
        cmd_go && cmd_op inside {[5'h01:5'h02], [5'h05:5'h06]}
        |=> $stable(flag_bits[5:1]) [*4])
        else $error("carry rotate touched other flags");
endmodule

bind rssd_datapath rssd_datapath_asserts u_chk (.clk_sys, .rst, .avs_address, .avs_write,
    .avs_byteenable, .avs_writedata, .avs_waitrequest, .mem_write, .mem_data, .skip_next,
    .flag_bits);

// ===== test/rssd_datapath_tb.sv
`timescale 1ns/100ps
module rssd_datapath_tb
    import rssd_pkg::*;
;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic [4:0] avs_address = 5'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest, mem_write, skip_next;
    logic [7:0] mem_data, working_register, last_byte;
    logic [5:0] flag_bits;
    logic [15:0] wr_cnt;
    logic skip_seen = 1'b0;
    logic skip_clr = 1'b0;
    logic [31:0] lfsr = 32'h263c190f;
    int error_cnt = 0;
    int comparisons = 0;
    int ma, mm, mi, mf, ew, es;

    rssd_datapath uut (.clk_sys, .rst, .avs_address, .avs_read, .avs_write,
        .avs_byteenable(4'hf), .avs_writedata, .avs_readdata, .avs_waitrequest,
        .mem_write, .mem_data, .skip_next, .working_register, .flag_bits);
    rssd_mem_model u_mem (.clk_sys, .rst, .mem_write, .mem_data, .wr_cnt, .last_byte);

    always #50 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        if (skip_clr) begin
            skip_seen <= 1'b0;
        end else if (skip_next === 1'b1) begin
            skip_seen <= 1'b1;
        end
    end

    function automatic int rnd();
        lfsr = {lfsr[30:0], 1'b0} ^ (lfsr[31] ? 32'h04c11db7 : 32'h0);
        return int'(lfsr[15:0]);
    endfunction

    task automatic end_of_test();
        $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // ****************************************
    // Avalon master: hold until waitrequest is sampled low
    // ****************************************
    task automatic bus(input logic w, input logic [4:0] a, input int d, output logic [31:0] q);
        int n;
        n = 0;
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= w;
        avs_read <= !w;
        @(posedge clk_sys);
        while (avs_waitrequest !== 1'b0) begin
            n++;
            if (n > 40) begin
                error_cnt++;
                end_of_test();
            end
            @(posedge clk_sys);
        end
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge clk_sys);
    endtask

    task automatic model(input int op, input int b);
        int c, o, bin, d, sa, so, r, cz;
        c = mf & 1;
        es = 0;
        r = 0;
        case (op)
            0: r = ((mm << 1) | (mm >> 7)) & 255;
            1, 2: r = ((mm << 1) | c) & 255;
            3, 4: r = (mm >> 1) | ((mm & 1) << 7);
            5, 6: r = (mm >> 1) | (c << 7);
            7, 8, 9, 10, 11, 12: begin
                o = (op == 8 || op == 11) ? mi : mm;
                bin = (op <= 9) ? 1 - c : 0;
                d = ma - o - bin;
                r = d & 255;
                sa = ma - ((ma & 128) << 1);
                so = o - ((o & 128) << 1);
                cz = int'(r == 0 && (op > 9 || ((mf >> RSSD_FL_CZ) & 1)));
                mf = int'(d >= 0) << RSSD_FL_C;
                mf |= int'((ma & 15) - (o & 15) - bin >= 0) << RSSD_FL_AC;
                mf |= int'(r == 0) << RSSD_FL_Z;
                mf |= int'(sa - so - bin < -128 || sa - so - bin > 127) << RSSD_FL_OV;
                mf |= int'(sa - so - bin < 0) << RSSD_FL_SC;
                mf |= cz << RSSD_FL_CZ;
            end
            13, 14: r = (mm + 255) & 255;
            15, 16: r = (mm + 1) & 255;
            17: es = (mm >> b) & 1;
            18: r = mm;
            19: r = 255;
            20: r = mm | (1 << b);
            default: r = 0;
        endcase
        if (op inside {1, 2}) mf = (mf & 62) | (mm >> 7);
        if (op inside {5, 6}) mf = (mf & 62) | (mm & 1);
        if (op inside {[13:16]}) es = int'(r == 0);
        if (op == 18) es = int'(mm != 0);
        ew = int'(op inside {1, 3, 5, 9, 12, 13, 15, 18, 19, 20});
        if (ew != 0) mm = r;
        else if (op inside {0, 2, 4, 6, 7, 8, 10, 11, 14, 16}) ma = r;
    endtask

    task automatic run_op(input int op, input int b);
        logic [31:0] q;
        int c0;
        bus(1, RSSD_OFS_MEM, mm, q);
        bus(1, RSSD_OFS_IMM, mi, q);
        bus(1, RSSD_OFS_WORK, ma, q);
        bus(1, RSSD_OFS_FLAGS, mf, q);
        c0 = wr_cnt;
        skip_clr <= 1'b1;
        @(posedge clk_sys);
        skip_clr <= 1'b0;
        bus(1, RSSD_OFS_CMD, (b << 8) | op, q);
        model(op, b);
        bus(0, RSSD_OFS_RESULT, 0, q);
        chk("result_skip", q[RSSD_RES_SKIP], es);
        chk("result_busy", q[RSSD_RES_BUSY], 0);
        if (ew != 0) chk("result_byte", q[7:0], mm);
        chk("skip_pin", skip_seen, es);
        chk("working", working_register, ma);
        chk("flags", flag_bits, mf);
        chk("mem_writes", wr_cnt - c0, ew);
        if (ew != 0) chk("mem_data", last_byte, mm);
        bus(0, RSSD_OFS_MEM, 0, q);
        chk("mem_reg", q, mm);
    endtask

    initial begin
        logic [31:0] q;
        repeat (5) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        chk("working_rst", working_register, 0);
        chk("flags_rst", flag_bits, 0);
        bus(0, 5'h18, 0, q);
        chk("unmapped", q, 0);
        for (int k = 0; k < 8; k++) begin
            for (int op = 0; op < 22; op++) begin
                mm = rnd() & 255;
                mi = rnd() & 255;
                mf = rnd() & 63;
                if (k == 0) mm = (op inside {13, 14}) ? 1 : ((op inside {15, 16}) ? 255 : mm);
                if (k == 2) mm = 0;
                ma = (k == 1) ? mm : rnd() & 255;
                run_op(op, k);
            end
        end
        end_of_test();
    end
endmodule
